// *** include/fuse_check_defs.svh ***
`ifndef FUSE_CHECK_DEFS_SVH
`define FUSE_CHECK_DEFS_SVH

// Rising edges on the mode pin that end the check window
`define FUSE_CHECK_EXIT_EDGES   2'h2
`define FUSE_CHECK_CNT_RESET    2'h0
// Idle level of the mode pin, held up by its pull-up
`define FUSE_TMS_IDLE           1'h1
// Clocks after reset before the synchronised pin level is real
`define FUSE_SETTLE_CYCLES      2'h2
`define FUSE_SETTLE_RESET       2'h0

`endif

// *** include/fuse_check_pkg.sv ***
package fuse_check_pkg;

    typedef enum logic [1:0] {
        armed,
        active,
        spent
    } fuse_mode_e;

    typedef struct packed {
        logic [1:0] settle_cnt;
        logic       tms_prev;
        logic       first_seen;
        logic [1:0] rise_cnt;
        fuse_mode_e mode;
        logic       sink_en;
        logic       fuse_mode;
        logic       bypass;
    } fuse_state_s;

endpackage

// *** logic/fuse_check.sv ***
// What this block does
// RQ1: After every power-on reset the first test port access may open a fuse continuity check.
// RQ2: The first falling edge on the mode pin after power-up activates the check mode.
// RQ3: A mode pin already low when reset releases activates the check mode without an edge.
// RQ4: The second rising edge on the mode pin ends the check mode.
// RQ5: Once ended, the check mode stays off whatever the mode pin does until the next power-on reset.
// RQ6: The continuity check current path from the data-in pin to ground is on only while active and the pin is low.
// RQ7: The outside controller keeps the mode pin high by default to avoid the extra current and false activation.
// RQ8: With the fuse blown, all test port access is refused and the test logic is forced to bypass.
// RQ9: Rising edges are counted from power-on reset by a counter only that reset clears, and two of them deactivate.
`timescale 1ns/100ps
`include "fuse_check_defs.svh"

// Two-stage synchroniser for a slow level from a pin
module level_sync #(
    parameter logic RESET_LEVEL = 1'h0
) (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic pin,
    output logic      level
);

    logic [1:0] stage_r;
    logic [1:0] stage_nxt;

    always_comb begin
        stage_nxt = {stage_r[0], pin};
    end

    // Idle level at reset so a freshly released chain shows no false edge
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            stage_r <= {2{RESET_LEVEL}};
        end else begin
            stage_r <= stage_nxt;
        end
    end

    // Only the second stage is read, never the metastable first one
    assign level = stage_r[1];

endmodule

module fuse_check
    import fuse_check_pkg::*;
(
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic tms,
    input  wire logic fuse_blown,
    output logic      continuity_check_current,
    output logic      fuse_check_active,
    output logic      test_bypass
);

    fuse_state_s state_r;
    fuse_state_s state_nxt;
    logic        tms_now;
    logic        fuse_now;
    logic        settled;
    logic        tms_fall;
    logic        tms_rise;

    level_sync #(
        .RESET_LEVEL (`FUSE_TMS_IDLE)
    ) u_tms_sync (
        .clk   (clk),
        .reset (reset),
        .pin   (tms),
        .level (tms_now)
    );

    // Fuse level is static but still crosses in from a pin
    level_sync #(
        .RESET_LEVEL (1'h0)
    ) u_fuse_sync (
        .clk   (clk),
        .reset (reset),
        .pin   (fuse_blown),
        .level (fuse_now)
    );

    assign settled  = (state_r.settle_cnt == `FUSE_SETTLE_CYCLES);
    // Edges count only once the previous sample was a real pin level
    assign tms_fall = state_r.first_seen & state_r.tms_prev & ~tms_now;
    assign tms_rise = state_r.first_seen & ~state_r.tms_prev & tms_now;

    always_comb begin
        state_nxt = state_r;
        state_nxt.tms_prev = tms_now;
        if (!settled) begin
            state_nxt.settle_cnt = state_r.settle_cnt + 2'h1;
        end
        // First settled sample stands in for the level at power-up
        if (settled) begin
            state_nxt.first_seen = 1'h1;
        end
        if (tms_rise && state_r.rise_cnt != `FUSE_CHECK_EXIT_EDGES) begin
            state_nxt.rise_cnt = state_r.rise_cnt + 2'h1; // [RQ9]
        end
        unique case (state_r.mode)
            armed: begin
                if (settled && !state_r.first_seen) begin
                    if (!tms_now) begin
                        state_nxt.mode = active; // [RQ1] [RQ3]
                    end
                end else if (tms_fall) begin
                    state_nxt.mode = active; // [RQ2]
                end
            end
            active: begin
                if (state_nxt.rise_cnt == `FUSE_CHECK_EXIT_EDGES) begin
                    state_nxt.mode = spent; // [RQ4] [RQ9]
                end
            end
            spent: begin
                state_nxt.mode = spent; // [RQ5]
            end
            // Unused code parks in spent so an upset never re-arms the check
            default: begin
                state_nxt.mode = spent;
            end
        endcase
        if (fuse_now) begin
            state_nxt.mode = spent; // [RQ8]
        end
        // Sink follows the same settled pin sample used for the mode
        state_nxt.sink_en   = (state_nxt.mode == active) && !tms_now; // [RQ6]
        state_nxt.fuse_mode = (state_nxt.mode == active);
        state_nxt.bypass    = fuse_now; // [RQ8]
    end

    // Only power-on reset clears the state, never TMS activity
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_r.settle_cnt <= `FUSE_SETTLE_RESET;
            state_r.tms_prev   <= `FUSE_TMS_IDLE;
            state_r.first_seen <= 1'b0;
            state_r.rise_cnt   <= `FUSE_CHECK_CNT_RESET; // [RQ5] [RQ9]
            state_r.mode       <= armed;
            state_r.sink_en    <= 1'b0;
            state_r.fuse_mode  <= 1'b0;
            state_r.bypass     <= 1'b0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign continuity_check_current = state_r.sink_en;
    assign fuse_check_active        = state_r.fuse_mode;
    assign test_bypass              = state_r.bypass;

endmodule

// *** testbench/fc_props.sv ***
`timescale 1ns/100ps
module fc_props (
    input wire logic clk,
    input wire logic reset,
    input wire logic tms,
    input wire logic fuse_blown,
    input wire logic continuity_check_current,
    input wire logic fuse_check_active,
    input wire logic test_bypass
);
    logic [3:0] since_rst_r;
    logic       left_r;

    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    // Pin to output takes three clocks; the first clocks see reset-time pin values
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            since_rst_r <= 4'h0;
            left_r      <= 1'h0;
        end else begin
            if (since_rst_r != 4'hF) begin
                since_rst_r <= since_rst_r + 4'h1;
            end
            if ($fell(fuse_check_active)) begin
                left_r <= 1'h1;
            end
        end
    end

    a_cur_needs_mode: assert property (continuity_check_current |-> fuse_check_active) else $error("no mode");
    a_exit_final: assert property ($fell(fuse_check_active) |=> !fuse_check_active[*8]) else $error("back");
    a_stays_off: assert property (left_r |-> !fuse_check_active) else $error("mode came back");
    a_cur_pin_high: assert property (since_rst_r >= 4'h4 && $past(tms, 3) |-> !continuity_check_current)
        else $error("current with pin high");
    a_cur_pin_low: assert property (since_rst_r >= 4'h4 && fuse_check_active && !$past(tms, 3)
        |-> continuity_check_current) else $error("no current with pin low");
    a_start_pin_low: assert property ($rose(fuse_check_active) |-> continuity_check_current)
        else $error("mode start without low pin");
    a_bypass_cause: assert property (test_bypass |-> fuse_blown) else $error("bypass without fuse");
    a_bypass_sets: assert property (since_rst_r >= 4'h4 && $past(fuse_blown, 3) |-> test_bypass)
        else $error("fuse without bypass");
    a_blown_no_mode: assert property (test_bypass |-> !fuse_check_active) else $error("mode with fuse");

    c_mode_on: cover property ($rose(fuse_check_active));
    c_mode_off: cover property ($fell(fuse_check_active));
    c_cur_gap: cover property ($fell(continuity_check_current) && fuse_check_active);
    c_bypass_on: cover property ($rose(test_bypass));
endmodule
bind fuse_check fc_props u_fc_props (
    .clk                      (clk),
    .reset                    (reset),
    .tms                      (tms),
    .fuse_blown               (fuse_blown),
    .continuity_check_current (continuity_check_current),
    .fuse_check_active        (fuse_check_active),
    .test_bypass              (test_bypass)
);

// *** testbench/jtag_model.sv ***
`timescale 1ns/100ps
module jtag_model (
    input  wire logic clk,
    output logic      tms = 1'h1
);
    task set(input logic v, input int n);
        repeat (n) @(posedge clk);
        #1 tms = v;
    endtask
endmodule

// *** testbench/fuse_check_test.sv ***
`timescale 1ns/100ps
module fuse_check_test;
    logic clk = 1'h0, reset = 1'h1, fuse_blown = 1'h0, tms, cur, act, byp;
    int   failures = 0, n_compared = 0;
    always #4 clk = ~clk;
    jtag_model u_jtag_model (.clk(clk), .tms(tms));
    fuse_check u_fuse_check (.clk(clk), .reset(reset), .tms(tms), .fuse_blown(fuse_blown), .test_bypass(byp),
        .continuity_check_current(cur), .fuse_check_active(act));
    task chk(input string n, input logic e, input logic g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %b seen %b", n, e, g);
        end
    endtask
    // Power-on reset with pin level and fuse state set before release
    task por(input logic lvl, input logic b);
        reset      = 1'h1;
        fuse_blown = b;
        u_jtag_model.set(lvl, 0);
        repeat (6) @(posedge clk);
        #1 reset = 1'h0;
    endtask
    // Each level lasts 10 clocks, half the 160 ns link period; outputs read off the edge
    task step(input logic lvl);
        u_jtag_model.set(lvl, 2);
        repeat (8) @(posedge clk);
        #1;
    endtask
    task walk;
        por(1'h1, 1'h0);
        step(1'h0);
        chk("active", 1'h1, act);
        chk("current", 1'h1, cur);
        step(1'h1);
        chk("active", 1'h1, act);
        chk("current", 1'h0, cur);
        step(1'h0);
        chk("current", 1'h1, cur);
        step(1'h1);
        chk("active", 1'h0, act);
        chk("current", 1'h0, cur);
        step(1'h0);
        chk("active", 1'h0, act);
        chk("current", 1'h0, cur);
        step(1'h1);
        step(1'h0);
        chk("active", 1'h0, act);
        chk("bypass", 1'h0, byp);
        $display("walk done");
    endtask
    task low_start;
        por(1'h0, 1'h0);
        step(1'h0);
        chk("active", 1'h1, act);
        chk("current", 1'h1, cur);
        step(1'h1);
        chk("active", 1'h1, act);
        chk("current", 1'h0, cur);
        step(1'h0);
        chk("current", 1'h1, cur);
        step(1'h1);
        chk("active", 1'h0, act);
        step(1'h0);
        chk("active", 1'h0, act);
        chk("current", 1'h0, cur);
        $display("low_start done");
    endtask
    task blown;
        por(1'h1, 1'h1);
        step(1'h0);
        chk("active", 1'h0, act);
        chk("current", 1'h0, cur);
        chk("bypass", 1'h1, byp);
        step(1'h1);
        step(1'h0);
        chk("active", 1'h0, act);
        chk("bypass", 1'h1, byp);
        $display("blown done");
    endtask
    task results;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        walk;
        low_start;
        blown;
        results;
    end
endmodule
